// [verilog/cpu_clock_generation_divider.sv]
// CPU clock generation: trim register, wake-up timer, divider and clock output
`timescale 1ns/10ps

module cpu_clock_generation_divider
   import cpu_clock_gen_pkg::*;
#(
   parameter int WAKE_EXTRA = cpu_clock_gen_pkg::WAKE_EXTRA_CYCLES
)
(
   // Clock and reset
   input wire logic mclk,
   input wire logic srst,
   // Special function register port
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic [7:0] sfr_wdata,
   output logic [7:0] sfr_rdata,
   // Configuration and calibration
   input wire logic [5:0] factory_trim,
   input wire cpu_clock_gen_pkg::osc_source_e clock_source_cfg,
   // Oscillator sources
   input wire logic crystal_input_pin,
   input wire logic rc_osc_tick,
   input wire logic wdog_osc_tick,
   // Port logic sharing the crystal output pin
   input wire logic port_out_data,
   input wire logic port_out_en,
   // Crystal output pin
   output logic crystal_output_pin_o,
   output logic crystal_output_pin_oe,
   // Clock enables and status
   output logic oscillator_clock,
   output logic cpu_clock,
   output logic peripheral_clock,
   output logic clock_ready,
   output logic [5:0] rc_trim_value,
   output logic low_power_clock_select
);

   import cpu_clock_gen_pkg::*;

   logic [7:0] trim_reg;
   logic [7:0] divider_reg;
   logic low_power_reg;
   logic [7:0] rdata_reg;
   logic xin_s1_reg;
   logic xin_s2_reg;
   logic xin_s3_reg;
   logic src_rc_reg;
   logic [7:0] div_active_reg;
   logic [8:0] div_cnt_reg;
   logic clkout_reg;
   logic pclk_phase_reg;
   logic [9:0] wake_osc_reg;
   logic [15:0] wake_time_reg;
   wake_state_e state_reg;
   wake_state_e state_next;

   // Register decode
   wire wr_trim = sfr_wr && (sfr_addr == TRIM_ADDR);
   wire wr_div = sfr_wr && (sfr_addr == DIVIDER_ADDR);
   wire wr_aux = sfr_wr && (sfr_addr == AUX_ONE_ADDR);
   wire [7:0] read_mux = (sfr_addr == TRIM_ADDR) ? trim_reg :
                         (sfr_addr == DIVIDER_ADDR) ? divider_reg :
                         (sfr_addr == AUX_ONE_ADDR) ? {low_power_reg, 7'h00} : READ_IDLE;

   // Source classification
   wire cfg_xtal = (clock_source_cfg == SRC_XTAL_LOW) ||
                   (clock_source_cfg == SRC_XTAL_MED) ||
                   (clock_source_cfg == SRC_XTAL_HIGH);
   wire crystal_in_use = cfg_xtal && !src_rc_reg;
   wire xin_edge = xin_s2_reg && !xin_s3_reg;
   wire cfg_tick = (clock_source_cfg == SRC_RC) ? rc_osc_tick :
                   (clock_source_cfg == SRC_WATCHDOG) ? wdog_osc_tick : xin_edge;
   wire osc_tick = src_rc_reg ? rc_osc_tick : cfg_tick;

   // Divider terminal count: 2N-1 oscillator ticks, or every tick for N = 0
   wire [8:0] div_last = {div_active_reg, 1'b0} - 9'h001;
   wire div_term = (div_active_reg == 8'h00) || (div_cnt_reg == div_last);
   wire running = (state_reg == WAKE_RUN);
   wire cpu_tick = running && osc_tick && div_term;
   wire [9:0] wake_limit = cfg_xtal ? XTAL_WAKE_OSC : RC_WAKE_OSC;

   // Register file; the trim field reloads from calibration on every reset
   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         trim_reg <= {TRIM_UPPER_RESET, factory_trim};
         divider_reg <= DIVIDER_RESET;
         low_power_reg <= LOW_POWER_RESET;
      end
      else
      begin
         if (wr_trim)
            trim_reg <= sfr_wdata;
         if (wr_div)
            divider_reg <= sfr_wdata;
         if (wr_aux)
            low_power_reg <= sfr_wdata[LOW_POWER_BIT];
      end
   end

   // Read data is registered so the bus sees a flop, not the decode tree
   always_ff @(posedge mclk)
   begin
      if (srst)
         rdata_reg <= READ_IDLE;
      else if (sfr_rd)
         rdata_reg <= read_mux;
   end

   // Crystal pin synchroniser; the third stage only feeds the edge detector
   always_ff @(posedge mclk)
   begin
      xin_s1_reg <= crystal_input_pin;
      xin_s2_reg <= xin_s1_reg;
      xin_s3_reg <= xin_s2_reg;
   end

   // Wake-up sequencer next state
   always_comb
   begin
      state_next = state_reg;
      unique case (state_reg)
         WAKE_OSC:
            if (osc_tick && (wake_osc_reg == wake_limit - 10'h001))
               state_next = WAKE_TIME;
         WAKE_TIME:
            if (wake_time_reg == 16'(WAKE_EXTRA - 1))
               state_next = WAKE_RUN;
         WAKE_RUN:
            state_next = WAKE_RUN;
      endcase
   end

   // Wake-up counters: oscillator ticks first, then a fixed mclk interval
   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         state_reg <= WAKE_OSC;
         wake_osc_reg <= 10'h000;
         wake_time_reg <= 16'h0000;
      end
      else
      begin
         state_reg <= state_next;
         if (state_reg == WAKE_OSC && osc_tick)
            wake_osc_reg <= wake_osc_reg + 10'h001;
         if (state_reg == WAKE_TIME)
            wake_time_reg <= wake_time_reg + 16'h0001;
      end
   end

   // Divider and source selection; once running, both only move at a CPU tick so no short
   // period ever reaches the CPU, at the cost of a slow divider settling late
   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         src_rc_reg <= 1'b0;
         div_active_reg <= DIVIDER_RESET;
         div_cnt_reg <= 9'h000;
      end
      else if (!running || cpu_tick)
      begin
         src_rc_reg <= trim_reg[RC_SEL_BIT];
         div_active_reg <= divider_reg;
         div_cnt_reg <= 9'h000;
      end
      else if (osc_tick)
         div_cnt_reg <= div_cnt_reg + 9'h001;
   end

   // Clock output toggles per CPU tick; peripheral phase halves the CPU rate
   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         clkout_reg <= 1'b0;
         pclk_phase_reg <= 1'b0;
      end
      else if (cpu_tick)
      begin
         clkout_reg <= !clkout_reg;
         pclk_phase_reg <= !pclk_phase_reg;
      end
   end

   // Pin sharing: never fight the crystal amplifier while it is in use
   wire clkout_on = trim_reg[CLKOUT_EN_BIT] && !crystal_in_use;
   wire port_on = port_out_en && !crystal_in_use && !trim_reg[CLKOUT_EN_BIT];
   assign crystal_output_pin_oe = clkout_on || port_on;
   assign crystal_output_pin_o = clkout_on ? clkout_reg : (port_on && port_out_data);

   // Outputs
   assign sfr_rdata = rdata_reg;
   assign oscillator_clock = osc_tick;
   assign cpu_clock = cpu_tick;
   assign peripheral_clock = cpu_tick && pclk_phase_reg;
   assign clock_ready = running;
   assign rc_trim_value = trim_reg[TRIM_CAL_MSB:0];
   assign low_power_clock_select = low_power_reg;

   // Helper: oscillator ticks since the last CPU tick, for the period check
   logic [8:0] gap_reg;
   always_ff @(posedge mclk)
   begin
      if (srst || !running)
         gap_reg <= 9'h000;
      else if (osc_tick)
         gap_reg <= cpu_tick ? 9'h000 : gap_reg + 9'h001;
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (srst);

   trim_reset_a: assert property (
      $past(srst) |-> trim_reg == {TRIM_UPPER_RESET, $past(factory_trim)})
      else $error("trim field not loaded from calibration at reset");

   // Only judged while the output was already on, so switching it on is no false toggle
   clkout_toggle_a: assert property (
      cpu_clock && clkout_on |=>
      crystal_output_pin_o != $past(crystal_output_pin_o) || !clkout_on)
      else $error("clock output did not toggle on CPU tick");

   port_drive_a: assert property (
      port_on |-> crystal_output_pin_oe && crystal_output_pin_o == port_out_data)
      else $error("port data not driven on free crystal output pin");

   crystal_release_a: assert property (
      crystal_in_use |-> !crystal_output_pin_oe)
      else $error("crystal output pin driven while crystal in use");

   rc_source_a: assert property (
      src_rc_reg |-> oscillator_clock == rc_osc_tick)
      else $error("RC source selected but oscillator not RC");

   wake_hold_a: assert property (
      !clock_ready |-> !cpu_clock)
      else $error("CPU clock ran during wake-up delay");

   wake_count_a: assert property (
      (state_reg == WAKE_OSC && osc_tick && wake_osc_reg == wake_limit - 10'h001)
      |=> state_reg == WAKE_TIME ##1 !clock_ready)
      else $error("wake-up oscillator count wrong");

   // Both wake-up counters must have run to their limits when the clock is let go
   wake_total_a: assert property (
      $rose(clock_ready) |->
      wake_osc_reg == wake_limit && wake_time_reg == 16'(WAKE_EXTRA))
      else $error("wake-up delay ended early or late");

   div_load_a: assert property (
      wr_div |=> divider_reg == $past(sfr_wdata))
      else $error("divider write not taken");

   div_period_a: assert property (
      cpu_clock && $past(clock_ready) |->
      10'(gap_reg) + 10'h001 == ((div_active_reg == 8'h00) ? 10'h001 : {1'b0, div_active_reg, 1'b0}))
      else $error("CPU clock period does not match divider");

   div_boundary_a: assert property (
      (clock_ready && !cpu_clock) |=> $stable(div_active_reg) && $stable(src_rc_reg))
      else $error("divider or source changed between CPU ticks");

   low_power_reset_a: assert property (
      $past(srst) |-> !low_power_clock_select)
      else $error("low-power select not cleared by reset");

   wdog_source_a: assert property (
      (clock_source_cfg == SRC_WATCHDOG && !src_rc_reg) |-> oscillator_clock == wdog_osc_tick)
      else $error("watchdog source not routed");

   pclk_half_a: assert property (
      peripheral_clock |-> cpu_clock ##1 !peripheral_clock)
      else $error("peripheral clock not half CPU clock");

   run_reached_c: cover property ($rose(clock_ready));
   div_change_c: cover property (clock_ready && cpu_clock && div_active_reg != divider_reg);
   rc_switch_c: cover property ($rose(src_rc_reg) && clock_ready);
   clkout_live_c: cover property (clkout_on && cpu_clock);
   ext_clock_c: cover property (clock_source_cfg == SRC_EXTERNAL && $rose(clock_ready));

endmodule

// [verilog/cpu_clock_gen_pkg.sv]
// Constants shared by the CPU clock generation and divider block
package cpu_clock_gen_pkg;

   // Register addresses on the special function register port
   localparam logic [7:0] TRIM_ADDR = 8'h96;
   localparam logic [7:0] DIVIDER_ADDR = 8'h95;
   localparam logic [7:0] AUX_ONE_ADDR = 8'ha2;

   // Field positions
   localparam int TRIM_CAL_MSB = 5;
   localparam int CLKOUT_EN_BIT = 6;
   localparam int RC_SEL_BIT = 7;
   localparam int LOW_POWER_BIT = 7;

   // Values after reset (trim calibration field comes from the factory store)
   localparam logic [1:0] TRIM_UPPER_RESET = 2'h0;
   localparam logic [7:0] DIVIDER_RESET = 8'h00;
   localparam logic LOW_POWER_RESET = 1'b0;
   localparam logic [7:0] READ_IDLE = 8'h00;

   // Wake-up delay in oscillator ticks
   localparam logic [9:0] XTAL_WAKE_OSC = 10'd992;
   localparam logic [9:0] RC_WAKE_OSC = 10'd224;

   // Extra wake-up time: least figure, rounded up to whole mclk cycles
   localparam int MCLK_PERIOD_PS = 8000;
   localparam int WAKE_EXTRA_US = 60;
   localparam int WAKE_EXTRA_CYCLES =
      (WAKE_EXTRA_US * 1000000 + MCLK_PERIOD_PS - 1) / MCLK_PERIOD_PS;

   // Oscillator source as configured at programming time
   typedef enum logic [2:0] {
      SRC_EXTERNAL = 3'h0,
      SRC_XTAL_LOW = 3'h1,
      SRC_XTAL_MED = 3'h2,
      SRC_XTAL_HIGH = 3'h3,
      SRC_RC = 3'h4,
      SRC_WATCHDOG = 3'h5
   } osc_source_e;

   // Wake-up sequencer states
   typedef enum logic [2:0] {
      WAKE_OSC = 3'b001,
      WAKE_TIME = 3'b010,
      WAKE_RUN = 3'b100
   } wake_state_e;

endpackage

// [verification/cpu_clock_generation_divider_test.sv]
// Self-checking bench for the CPU clock generation and divider block
`timescale 1ns/10ps

module cpu_clock_generation_divider_test;
   import cpu_clock_gen_pkg::*;

   logic mclk, srst, sfr_wr, sfr_rd, crystal_input_pin, rc_osc_tick, wdog_osc_tick;
   logic port_out_data, port_out_en, crystal_output_pin_o, crystal_output_pin_oe;
   logic oscillator_clock, cpu_clock, peripheral_clock, clock_ready, low_power_clock_select;
   logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, rd;
   logic [5:0] factory_trim, rc_trim_value;
   logic [15:0] n;
   osc_source_e clock_source_cfg;
   int err_count, comparisons, cnt, rc_per, wd_per;

   // Short extra wake-up time keeps the run brief
   cpu_clock_generation_divider #(.WAKE_EXTRA(4)) DUT (.mclk(mclk), .srst(srst),
      .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
      .sfr_rdata(sfr_rdata), .factory_trim(factory_trim), .clock_source_cfg(clock_source_cfg),
      .crystal_input_pin(crystal_input_pin), .rc_osc_tick(rc_osc_tick),
      .wdog_osc_tick(wdog_osc_tick), .port_out_data(port_out_data), .port_out_en(port_out_en),
      .crystal_output_pin_o(crystal_output_pin_o), .crystal_output_pin_oe(crystal_output_pin_oe),
      .oscillator_clock(oscillator_clock), .cpu_clock(cpu_clock),
      .peripheral_clock(peripheral_clock), .clock_ready(clock_ready),
      .rc_trim_value(rc_trim_value), .low_power_clock_select(low_power_clock_select));

   // Clock at 125 MHz
   initial
   begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end

   // Oscillator ticks; crystal pin rises every fourth cycle
   always @(posedge mclk)
   begin
      cnt <= cnt + 1;
      rc_osc_tick <= #1 (cnt % rc_per == 0);
      wdog_osc_tick <= #1 (cnt % wd_per == 0);
      crystal_input_pin <= #1 cnt[1];
   end

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk) #1;
      sfr_addr = a;
      sfr_wdata = d;
      sfr_wr = 1'b1;
      @(posedge mclk) #1;
      sfr_wr = 1'b0;
   endtask

   // Read data is registered, so it is taken one edge after the strobe
   task automatic sfr_read(input logic [7:0] a, output logic [7:0] d);
      @(posedge mclk) #1;
      sfr_addr = a;
      sfr_rd = 1'b1;
      @(posedge mclk) #1;
      sfr_rd = 1'b0;
      d = sfr_rdata;
   endtask

   // Reset, then count cycles until the wake-up delay ends
   task automatic rst(input osc_source_e src, output logic [15:0] w);
      @(posedge mclk) #1;
      srst = 1'b1;
      clock_source_cfg = src;
      repeat (12) @(posedge mclk);
      #1 srst = 1'b0;
      for (w = 0; clock_ready !== 1'b1 && w < 5000; w++) @(negedge mclk);
   endtask

   // Cycles between two pulses of cpu_clock (s=0) or peripheral_clock (s=1)
   task automatic gap(input int s, output logic [15:0] g);
      int i;
      @(negedge mclk);
      for (i = 0; i < 3000 && (s ? peripheral_clock : cpu_clock) !== 1'b1; i++) @(negedge mclk);
      g = 0;
      do
      begin
         @(negedge mclk);
         g++;
      end while ((s ? peripheral_clock : cpu_clock) !== 1'b1 && g < 3000);
   endtask

   task automatic t_reset();
      rst(SRC_RC, n);
      check("rc wake", 16'(n >= 224 && n <= 232), 16'h1);
      sfr_read(TRIM_ADDR, rd);
      check("trim reset", 16'(rd), 16'h002b);
      check("trim port", 16'(rc_trim_value), 16'h002b);
      sfr_read(DIVIDER_ADDR, rd);
      check("divider reset", 16'(rd), 16'h0000);
      sfr_read(AUX_ONE_ADDR, rd);
      check("aux reset", 16'(rd), 16'h0000);
      sfr_read(8'h10, rd);
      check("unmapped read", 16'(rd), 16'h0000);
      $display("test reset done");
   endtask

   // Divider taken while running; period in ticks is 2N, or 1 for zero
   task automatic t_divider();
      logic [7:0] tab [4] = '{8'h00, 8'h01, 8'h03, 8'hff};
      foreach (tab[k])
      begin
         sfr_write(DIVIDER_ADDR, tab[k]);
         gap(0, n);
         gap(0, n);
         check("cpu period", n, tab[k] == 0 ? 16'h1 : 16'(2 * tab[k]));
         gap(1, n);
         gap(1, n);
         check("periph period", n, tab[k] == 0 ? 16'h2 : 16'(4 * tab[k]));
      end
      $display("test divider done");
   endtask

   // A slow divider settles only at its next CPU tick, so wait for it first
   task automatic t_clkout();
      sfr_write(DIVIDER_ADDR, 8'h02);
      gap(0, n);
      gap(0, n);
      check("cpu period two", n, 16'h0004);
      sfr_read(TRIM_ADDR, rd);
      sfr_write(TRIM_ADDR, rd | 8'h40);
      sfr_read(TRIM_ADDR, rd);
      check("trim kept", 16'(rd), 16'h006b);
      repeat (20) @(negedge mclk);
      check("clkout oe", 16'(crystal_output_pin_oe), 16'h1);
      for (n = 0; crystal_output_pin_o !== 1'b0 && n < 50; n++) @(negedge mclk);
      for (n = 0; crystal_output_pin_o !== 1'b1 && n < 50; n++) @(negedge mclk);
      for (n = 0; crystal_output_pin_o === 1'b1 && n < 50; n++) @(negedge mclk);
      check("clkout half", n, 16'h4);
      sfr_write(TRIM_ADDR, rd & 8'hbf);
      port_out_en = 1'b1;
      port_out_data = 1'b1;
      repeat (3) @(negedge mclk);
      check("port drive", 16'({crystal_output_pin_oe, crystal_output_pin_o}), 16'h3);
      @(posedge mclk) #1;
      port_out_data = 1'b0;
      @(negedge mclk);
      check("port data", 16'(crystal_output_pin_o), 16'h0);
      @(posedge mclk) #1;
      port_out_en = 1'b0;
      @(negedge mclk);
      check("port release", 16'(crystal_output_pin_oe), 16'h0);
      $display("test clock output done");
   endtask

   task automatic t_lowpower();
      // Slow the CPU clock to 125/16 MHz before asking for low power
      sfr_write(DIVIDER_ADDR, 8'h08);
      sfr_write(AUX_ONE_ADDR, 8'hff);
      sfr_read(AUX_ONE_ADDR, rd);
      check("aux bits", 16'(rd), 16'h0080);
      check("low power", 16'(low_power_clock_select), 16'h1);
      wd_per = 1;
      rst(SRC_WATCHDOG, n);
      check("wd wake", 16'(n >= 224 && n <= 232), 16'h1);
      check("low power reset", 16'(low_power_clock_select), 16'h0);
      $display("test low power done");
   endtask

   // Watchdog source ticks every fourth cycle, RC every cycle
   task automatic t_rcsel();
      wd_per = 4;
      gap(0, n);
      gap(0, n);
      check("wd period", n, 16'h4);
      sfr_read(TRIM_ADDR, rd);
      sfr_write(TRIM_ADDR, rd | 8'h80);
      gap(0, n);
      gap(0, n);
      check("rc select", n, 16'h1);
      $display("test rc select done");
   endtask

   task automatic t_xtal();
      rst(SRC_XTAL_HIGH, n);
      check("xtal wake", 16'(n >= 3968 && n <= 3990), 16'h1);
      sfr_write(TRIM_ADDR, 8'h6b);
      repeat (4) @(negedge mclk);
      check("no clkout xtal", 16'(crystal_output_pin_oe), 16'h0);
      // Crystal to RC without a reset; RC ticks every cycle
      sfr_read(TRIM_ADDR, rd);
      sfr_write(TRIM_ADDR, rd | 8'h80);
      gap(0, n);
      gap(0, n);
      check("xtal to rc", n, 16'h1);
      $display("test crystal done");
   endtask

   // External clock on the crystal input pin, one rising edge every fourth cycle
   task automatic t_ext();
      // Reset stands in for the shared reset pin, needed at this clock rate
      rst(SRC_EXTERNAL, n);
      check("ext wake", 16'(n >= 896 && n <= 904), 16'h1);
      sfr_read(TRIM_ADDR, rd);
      sfr_write(TRIM_ADDR, rd | 8'h40);
      @(negedge mclk);
      check("ext clkout oe", 16'(crystal_output_pin_oe), 16'h1);
      n = 0;
      repeat (40)
      begin
         @(negedge mclk);
         n = n + 16'(oscillator_clock);
      end
      check("ext osc ticks", n, 16'h000a);
      $display("test external clock done");
   endtask

   // Watchdog against a hang
   initial
   begin
      #200000;
      err_count++;
      stop_test();
   end

   // Main sequence
   initial
   begin
      srst = 1'b1;
      {sfr_wr, sfr_rd, port_out_data, port_out_en} = '0;
      {sfr_addr, sfr_wdata} = '0;
      {crystal_input_pin, rc_osc_tick, wdog_osc_tick} = '0;
      factory_trim = 6'h2b;
      clock_source_cfg = SRC_RC;
      {err_count, comparisons, cnt} = '0;
      rc_per = 1;
      wd_per = 1;
      t_reset();
      t_divider();
      t_clkout();
      t_lowpower();
      t_rcsel();
      t_xtal();
      t_ext();
      stop_test();
   end
endmodule
